// ==== logic/see_bulk_prog.sv ====
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Bulk erase sets every array bit to one.
// - Bulk erase starts on last address bit edge.
// - Bulk write starts on its final instruction edge.
// - Low eight or nine address bits ignored.
// - Started cycle completes without further serial clocks.
// - Bulk write stores data word everywhere.
// - Bulk write erases first; needs unlock latch set.
// - Busy status driven from cycle start until next start or deselect.
// - Status reads zero busy, one ready.
// - Deselect releases the serial output.
// - Bulk erase timed under fifteen milliseconds.
// - Bulk write timed under thirty milliseconds.
// - Programming finishes even after select falls.
// - Select low holds serial control in reset.
// - Bits sampled on rising serial clock edges.
// - Serial clock may pause at either level.
// - Clock ignored deselected and before start.
// - Exact bit count, then ignore until start.
// - Width select high sixteen-bit, low eight-bit.
// - Program permit low blocks all programming.
// - Start is select and data high together.
// - Programming locked after reset until unlocked.
module see_bulk_prog #(
  parameter int unsigned ERASE_ALL_CYCLES = see_pkg::ERASE_ALL_CYCLES,
  parameter int unsigned WRITE_ALL_CYCLES = see_pkg::WRITE_ALL_CYCLES
) (
  // System clock and reset.
  input  wire logic                         SYS_CLK,
  input  wire logic                         RESET,
  // Serial link from the bus master.
  input  wire logic                         SCLK,
  input  wire logic                         CHIP_SELECT,
  input  wire logic                         SERIAL_IN,
  output logic                              SERIAL_OUT,
  output logic                              SERIAL_OUT_OE,
  // Strap pins.
  input  wire logic                         WORD_WIDTH_SELECT,
  input  wire logic                         PROGRAM_PERMIT,
  // Status.
  output logic                              PROG_BUSY,
  output logic                              PROG_UNLOCKED,
  // Array observation port.
  input  wire logic [see_pkg::ARRAY_AW-1:0] MEM_RD_ADDR,
  output logic      [15:0]                  MEM_RD_DATA
);

  // Serial clock domain.
  see_pkg::see_ser_state_t ser_state_r;
  see_pkg::see_ser_state_t ser_state_nxt;
  logic [4:0]              bit_cnt_r;
  logic [4:0]              bit_cnt_nxt;
  logic [3:0]              hdr_r;
  logic [3:0]              hdr_nxt;
  logic [15:0]             data_sr_r;
  logic [15:0]             data_sr_nxt;
  logic [4:0]              frame_len;
  logic                    has_data;
  logic                    start_hit;
  logic                    cmd_issue;
  logic                    org_s1_r;
  logic                    org_s2_r;
  logic                    start_tgl_r;
  logic                    cmd_tgl_r;
  logic [1:0]              cmd_code_r;
  logic [15:0]             cmd_data_r;
  logic                    cmd_x8_r;

  // System clock domain.
  logic [2:0]              cmd_sync_r;
  logic [2:0]              start_sync_r;
  logic [1:0]              cs_sync_r;
  logic [1:0]              pe_sync_r;
  logic                    cmd_evt;
  logic                    start_evt;
  logic                    bulk_go;
  see_pkg::see_prg_state_t prg_state_r;
  see_pkg::see_prg_state_t prg_state_nxt;
  logic [see_pkg::ARRAY_AW-1:0] sweep_addr_r;
  logic                    sweep_last;
  logic                    fill_pending_r;
  logic [15:0]             fill_word_r;
  logic [see_pkg::TIMER_W-1:0] timer_r;
  logic [see_pkg::TIMER_W-1:0] limit_r;
  logic                    timer_done;
  logic                    unlocked_r;
  logic                    show_status_r;
  logic                    mem_we;
  logic [15:0]             mem_wd;
  logic [15:0]             mem [see_pkg::ARRAY_WORDS];

  // The width strap is static, but it is still brought into the link domain through two flops.
  // The link clock only runs inside frames, so the strap is taken up by the idle clocks that lead a frame.
  // A change of width between frames is therefore seen by the very next instruction.
  always_ff @(posedge SCLK or posedge RESET) begin
    if (RESET) begin
      org_s1_r <= 1'b1;
      org_s2_r <= 1'b1;
    end else begin
      org_s1_r <= WORD_WIDTH_SELECT;
      org_s2_r <= org_s1_r;
    end
  end

  // Frame length depends on the opcode, the bulk sub-code and the organisation.
  always_comb begin
    has_data  = (hdr_r[3:2] == see_pkg::OP_WRITE_WORD) ||
                ((hdr_r[3:2] == see_pkg::OP_BULK) && (hdr_r[1:0] == see_pkg::CMD_WRITE_ALL));
    frame_len = see_pkg::OPCODE_BITS + (org_s2_r ? see_pkg::ABITS_X16 : see_pkg::ABITS_X8);
    if (has_data) begin
      frame_len = frame_len + (org_s2_r ? see_pkg::DBITS_X16 : see_pkg::DBITS_X8);
    end
  end

  // Next state of the serial front end; every move happens on a rising serial clock edge.
  always_comb begin
    ser_state_nxt = ser_state_r;
    bit_cnt_nxt   = bit_cnt_r;
    hdr_nxt       = hdr_r;
    data_sr_nxt   = data_sr_r;
    start_hit     = 1'b0;
    cmd_issue     = 1'b0;
    case (ser_state_r)
      see_pkg::SER_WAIT: begin
        if (SERIAL_IN) begin
          start_hit     = 1'b1;
          ser_state_nxt = see_pkg::SER_SHIFT;
          bit_cnt_nxt   = 5'h00;
        end
      end
      see_pkg::SER_SHIFT: begin
        bit_cnt_nxt = bit_cnt_r + 5'h01;
        if (bit_cnt_r < see_pkg::HDR_BITS) begin
          hdr_nxt = {hdr_r[2:0], SERIAL_IN};
        end
        data_sr_nxt = {data_sr_r[14:0], SERIAL_IN};
        if (bit_cnt_nxt == frame_len) begin
          ser_state_nxt = see_pkg::SER_WAIT;
          cmd_issue     = (hdr_r[3:2] == see_pkg::OP_BULK);
        end
      end
      default: begin
        ser_state_nxt = see_pkg::SER_WAIT;
      end
    endcase
  end

  // Serial control is held in reset whenever select is low; a paused clock simply holds state.
  // Select acts as an asynchronous clear here because the link clock may be stopped when it falls.
  // Without it a cut frame would leave a half-counted header behind for the next instruction.
  always_ff @(posedge SCLK or negedge CHIP_SELECT) begin
    if (!CHIP_SELECT) begin
      ser_state_r <= see_pkg::SER_WAIT;
      bit_cnt_r   <= 5'h00;
      hdr_r       <= 4'h0;
      data_sr_r   <= 16'h0000;
    end else begin
      ser_state_r <= ser_state_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      hdr_r       <= hdr_nxt;
      data_sr_r   <= data_sr_nxt;
    end
  end

  // Events toward the system domain travel as toggles with a payload that stays put between them.
  // The payload changes only together with the toggle, and the toggle needs two system edges to be seen.
  // By then the payload has settled, so it may be read in the system domain without its own synchroniser.
  // Two instructions can never come closer than the select low time, which spans several system cycles.
  always_ff @(posedge SCLK or posedge RESET) begin
    if (RESET) begin
      start_tgl_r <= 1'b0;
      cmd_tgl_r   <= 1'b0;
      cmd_code_r  <= see_pkg::CMD_LOCK;
      cmd_data_r  <= 16'h0000;
      cmd_x8_r    <= 1'b0;
    end else begin
      if (CHIP_SELECT && start_hit) begin
        start_tgl_r <= ~start_tgl_r;
      end
      if (CHIP_SELECT && cmd_issue) begin
        cmd_tgl_r  <= ~cmd_tgl_r;
        cmd_code_r <= hdr_r[1:0];
        cmd_data_r <= data_sr_nxt;
        cmd_x8_r   <= ~org_s2_r;
      end
    end
  end

  // Synchronisers into the system domain; only the later stages are inspected.
  // The first stage of each chain may go metastable and is read by nothing but the stage after it.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cmd_sync_r   <= 3'h0;
      start_sync_r <= 3'h0;
      cs_sync_r    <= 2'h0;
      pe_sync_r    <= 2'h0;
    end else begin
      cmd_sync_r   <= {cmd_sync_r[1:0], cmd_tgl_r};
      start_sync_r <= {start_sync_r[1:0], start_tgl_r};
      cs_sync_r    <= {cs_sync_r[0], CHIP_SELECT};
      pe_sync_r    <= {pe_sync_r[0], PROGRAM_PERMIT};
    end
  end

  // Edge detection on the settled toggle stages.
  assign cmd_evt   = cmd_sync_r[2] ^ cmd_sync_r[1];
  assign start_evt = start_sync_r[2] ^ start_sync_r[1];

  // A bulk instruction runs only when unlocked, permitted and idle.
  assign bulk_go = cmd_evt && (prg_state_r == see_pkg::PRG_IDLE) && unlocked_r && pe_sync_r[1] &&
                   ((cmd_code_r == see_pkg::CMD_ERASE_ALL) || (cmd_code_r == see_pkg::CMD_WRITE_ALL));

  // The unlock latch starts cleared and follows the unlock and lock instructions.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      unlocked_r <= 1'b0;
    end else if (cmd_evt && (cmd_code_r == see_pkg::CMD_UNLOCK)) begin
      unlocked_r <= 1'b1;
    end else if (cmd_evt && (cmd_code_r == see_pkg::CMD_LOCK)) begin
      unlocked_r <= 1'b0;
    end
  end

  // Sweep and timer status used by the programming sequencer.
  assign sweep_last = (sweep_addr_r == see_pkg::ARRAY_AW'(see_pkg::ARRAY_WORDS - 1));
  assign timer_done = (timer_r >= limit_r);

  // Programming sequencer: erase sweep, optional fill sweep, then wait out the cycle time.
  always_comb begin
    prg_state_nxt = prg_state_r;
    case (prg_state_r)
      see_pkg::PRG_IDLE: begin
        if (bulk_go) begin
          prg_state_nxt = see_pkg::PRG_ERASE;
        end
      end
      see_pkg::PRG_ERASE: begin
        if (sweep_last) begin
          prg_state_nxt = fill_pending_r ? see_pkg::PRG_FILL : see_pkg::PRG_WAIT;
        end
      end
      see_pkg::PRG_FILL: begin
        if (sweep_last) begin
          prg_state_nxt = see_pkg::PRG_WAIT;
        end
      end
      see_pkg::PRG_WAIT: begin
        if (timer_done) begin
          prg_state_nxt = see_pkg::PRG_IDLE;
        end
      end
      default: begin
        prg_state_nxt = see_pkg::PRG_IDLE;
      end
    endcase
  end

  // Sequencer state; it runs on the system clock, so no serial edges or select are needed.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prg_state_r <= see_pkg::PRG_IDLE;
    end else begin
      prg_state_r <= prg_state_nxt;
    end
  end

  // Sweep address walks the whole array once per sweep.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sweep_addr_r <= '0;
    end else if ((prg_state_r == see_pkg::PRG_ERASE) || (prg_state_r == see_pkg::PRG_FILL)) begin
      sweep_addr_r <= sweep_addr_r + see_pkg::ARRAY_AW'(1);
    end else begin
      sweep_addr_r <= '0;
    end
  end

  // Fill word and sweep choice are latched when a bulk cycle starts.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fill_pending_r <= 1'b0;
      fill_word_r    <= see_pkg::ERASED_WORD;
    end else if (bulk_go) begin
      fill_pending_r <= (cmd_code_r == see_pkg::CMD_WRITE_ALL);
      fill_word_r    <= cmd_x8_r ? {cmd_data_r[7:0], cmd_data_r[7:0]} : cmd_data_r;
    end
  end

  // Cycle timer; the limit is the typical cycle time, which lies inside the maximum.
  // The timer counts from the start of the cycle, so the sweeps are part of the cycle time.
  // When the limit is shorter than the sweeps, the sweeps alone set the length of the cycle.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      timer_r <= '0;
      limit_r <= '0;
    end else if (bulk_go) begin
      timer_r <= '0;
      if (cmd_code_r == see_pkg::CMD_WRITE_ALL) begin
        limit_r <= see_pkg::TIMER_W'(WRITE_ALL_CYCLES);
      end else begin
        limit_r <= see_pkg::TIMER_W'(ERASE_ALL_CYCLES);
      end
    end else if ((prg_state_r != see_pkg::PRG_IDLE) && !timer_done) begin
      timer_r <= timer_r + see_pkg::TIMER_W'(1);
    end
  end

  // Array write port: ones during the erase sweep, the fill word during the fill sweep.
  always_comb begin
    mem_we = (prg_state_r == see_pkg::PRG_ERASE) || (prg_state_r == see_pkg::PRG_FILL);
    mem_wd = (prg_state_r == see_pkg::PRG_FILL) ? fill_word_r : see_pkg::ERASED_WORD;
  end

  // The array itself keeps no reset, as its contents are meant to outlive one.
  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      mem[sweep_addr_r] <= mem_wd;
    end
  end

  // Registered observation read of the array.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      MEM_RD_DATA <= 16'h0000;
    end else begin
      MEM_RD_DATA <= mem[MEM_RD_ADDR];
    end
  end

  // Status display: set when a cycle starts, dropped by a new start bit or by deselect.
  // A start of cycle wins over a clear in the same cycle, so a fresh cycle always shows busy.
  // Once dropped, the display stays off even if the host selects again while the cycle runs.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      show_status_r <= 1'b0;
    end else if (bulk_go) begin
      show_status_r <= 1'b1;
    end else if (start_evt || !cs_sync_r[1]) begin
      show_status_r <= 1'b0;
    end
  end

  // Output pin drivers; status needs no serial clock, so it is timed on the system clock.
  // The host may poll the pin with the link clock stopped, so the status must not wait for link edges.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SERIAL_OUT    <= 1'b0;
      SERIAL_OUT_OE <= 1'b0;
    end else begin
      SERIAL_OUT    <= (prg_state_r == see_pkg::PRG_IDLE);
      SERIAL_OUT_OE <= show_status_r && cs_sync_r[1];
    end
  end

  // Block status outputs.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PROG_BUSY     <= 1'b0;
      PROG_UNLOCKED <= 1'b0;
    end else begin
      PROG_BUSY     <= (prg_state_r != see_pkg::PRG_IDLE);
      PROG_UNLOCKED <= unlocked_r;
    end
  end

endmodule
`default_nettype wire

// ==== logic/see_pkg.sv ====
package see_pkg;

  // Serial framing: bit counts after the start bit.
  localparam int unsigned SER_CNT_W  = 5;
  localparam logic [4:0]  OPCODE_BITS = 5'h02;
  localparam logic [4:0]  HDR_BITS    = 5'h04;
  localparam logic [4:0]  ABITS_X16   = 5'h0a;
  localparam logic [4:0]  ABITS_X8    = 5'h0b;
  localparam logic [4:0]  DBITS_X16   = 5'h10;
  localparam logic [4:0]  DBITS_X8    = 5'h08;

  // Opcodes and the sub-codes carried in the top two address bits of opcode 00.
  localparam logic [1:0] OP_BULK        = 2'h0;
  localparam logic [1:0] OP_WRITE_WORD  = 2'h1;
  localparam logic [1:0] CMD_LOCK       = 2'h0;
  localparam logic [1:0] CMD_WRITE_ALL  = 2'h1;
  localparam logic [1:0] CMD_ERASE_ALL  = 2'h2;
  localparam logic [1:0] CMD_UNLOCK     = 2'h3;

  // Array geometry, as sixteen-bit words.
  localparam int unsigned ARRAY_WORDS = 1024;
  localparam int unsigned ARRAY_AW    = 10;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Timing in microseconds and nanoseconds, and the derived cycle counts.
  localparam int unsigned CLK_MHZ           = 125;
  localparam int unsigned ERASE_ALL_TYP_US  = 8000;
  localparam int unsigned ERASE_ALL_MAX_US  = 15000;
  localparam int unsigned WRITE_ALL_TYP_US  = 16000;
  localparam int unsigned WRITE_ALL_MAX_US  = 30000;
  localparam int unsigned ERASE_ALL_CYCLES  = ERASE_ALL_TYP_US * CLK_MHZ;
  localparam int unsigned WRITE_ALL_CYCLES  = WRITE_ALL_TYP_US * CLK_MHZ;
  localparam int unsigned SELECT_LOW_NS     = 250;
  localparam int unsigned SELECT_LOW_CYCLES = (SELECT_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMER_W           = 22;

  // Serial front-end states.
  typedef enum logic [1:0] {
    SER_WAIT  = 2'b01,
    SER_SHIFT = 2'b10
  } see_ser_state_t;

  // Self-timed programming states.
  typedef enum logic [3:0] {
    PRG_IDLE  = 4'b0001,
    PRG_ERASE = 4'b0010,
    PRG_FILL  = 4'b0100,
    PRG_WAIT  = 4'b1000
  } see_prg_state_t;

endpackage

// ==== sim/see_bulk_prog_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the bulk programming block.
module see_bulk_prog_properties #(
  parameter int unsigned ERASE_ALL_CYCLES = see_pkg::ERASE_ALL_CYCLES,
  parameter int unsigned WRITE_ALL_CYCLES = see_pkg::WRITE_ALL_CYCLES
) (
  // Clock and reset.
  input wire logic                         SYS_CLK,
  input wire logic                         RESET,
  // Pins and status.
  input wire logic                         CHIP_SELECT,
  input wire logic                         SERIAL_OUT,
  input wire logic                         SERIAL_OUT_OE,
  input wire logic                         PROGRAM_PERMIT,
  input wire logic                         PROG_BUSY,
  input wire logic                         PROG_UNLOCKED,
  input wire logic [see_pkg::ARRAY_AW-1:0] MEM_RD_ADDR,
  input wire logic [15:0]                  MEM_RD_DATA
);
  localparam int unsigned BUSY_MAX = (WRITE_ALL_CYCLES > 2100 ? WRITE_ALL_CYCLES : 2100) + 16;
  logic [31:0] busy_cnt_r;
  logic        done_r;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Length of the running cycle.
  always_ff @(posedge SYS_CLK) begin
    busy_cnt_r <= (RESET || !PROG_BUSY) ? 32'h0 : busy_cnt_r + 32'h1;
  end
  // The array holds defined values once a cycle has ended.
  always_ff @(posedge SYS_CLK) begin
    done_r <= !RESET && (done_r || $fell(PROG_BUSY));
  end
  sequence s_quiet;
    (done_r && !PROG_BUSY) [*3] ##0 $stable(MEM_RD_ADDR) ##1 !PROG_BUSY;
  endsequence
  property p_busy_shown;
    $rose(SERIAL_OUT_OE) |-> !SERIAL_OUT ##[0:3] PROG_BUSY;
  endproperty
  property p_release;
    !CHIP_SELECT [*6] |-> !SERIAL_OUT_OE;
  endproperty
  property p_ready_holds;
    SERIAL_OUT_OE && SERIAL_OUT |=> !SERIAL_OUT_OE || SERIAL_OUT;
  endproperty
  property p_permit_blocks;
    !PROGRAM_PERMIT [*8] |=> !$rose(PROG_BUSY);
  endproperty
  property p_lock_blocks;
    !PROG_UNLOCKED [*8] |=> !$rose(PROG_BUSY);
  endproperty
  property p_busy_bound;
    PROG_BUSY |-> busy_cnt_r <= BUSY_MAX;
  endproperty
  property p_full_cycle;
    $fell(PROG_BUSY) |-> busy_cnt_r + 32'h8 >= ERASE_ALL_CYCLES;
  endproperty
  property p_array_still;
    s_quiet |-> $stable(MEM_RD_DATA);
  endproperty
  a_busy_shown: assert property (p_busy_shown)
    else $error("status pin did not start busy");
  a_release: assert property (p_release)
    else $error("status pin driven while deselected");
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready status went back to busy");
  a_permit_blocks: assert property (p_permit_blocks)
    else $error("cycle started with programming blocked");
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("cycle started while locked");
  a_busy_bound: assert property (p_busy_bound)
    else $error("programming cycle too long");
  a_full_cycle: assert property (p_full_cycle)
    else $error("programming cycle ended early");
  a_array_still: assert property (p_array_still)
    else $error("array changed while idle");
endmodule
bind see_bulk_prog see_bulk_prog_properties #(
  .ERASE_ALL_CYCLES(ERASE_ALL_CYCLES), .WRITE_ALL_CYCLES(WRITE_ALL_CYCLES)
) u_see_bulk_prog_properties (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CHIP_SELECT(CHIP_SELECT), .SERIAL_OUT(SERIAL_OUT),
  .SERIAL_OUT_OE(SERIAL_OUT_OE), .PROGRAM_PERMIT(PROGRAM_PERMIT), .PROG_BUSY(PROG_BUSY),
  .PROG_UNLOCKED(PROG_UNLOCKED), .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_DATA(MEM_RD_DATA)
);
`default_nettype wire

// ==== sim/see_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Serial bus master; its 15 ns clock stands low between frames.
module see_host_model (
  // Serial link.
  output var logic SCLK,
  output var logic CHIP_SELECT,
  output var logic SERIAL_IN
);
  // Idle link from time zero.
  initial begin
    SCLK = 1'h0;
    CHIP_SELECT = 1'h0;
    SERIAL_IN = 1'h0;
  end
  // Sends n bits of v, first bit first, framed by idle clocks and paused in mid-frame.
  task automatic frame(input logic [31:0] v, input int n);
    int i;
    #3;
    CHIP_SELECT = 1'h1;
    for (i = n + 2; i >= -2; i--) begin
      SERIAL_IN = (i >= n || i < 0) ? 1'h0 : v[i];
      #8 SCLK = 1'h1;
      #7 SCLK = 1'h0;
      if (i == 6) #40;
    end
    SERIAL_IN = ~SERIAL_IN;
  endtask
  // Ends an instruction and keeps select low long enough.
  task automatic deselect();
    CHIP_SELECT = 1'h0;
    #260;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: every array word is compared with one expected word after each command once a cycle has run.
module tb_top;
  localparam int unsigned CYC = 3000;
  logic                         SYS_CLK = 1'h0;
  logic                         RESET;
  logic                         WORD_WIDTH_SELECT = 1'h1;
  logic                         PROGRAM_PERMIT = 1'h1;
  logic [see_pkg::ARRAY_AW-1:0] MEM_RD_ADDR = 10'h000;
  logic                         SCLK;
  logic                         CHIP_SELECT;
  logic                         SERIAL_IN;
  logic                         SERIAL_OUT;
  logic                         SERIAL_OUT_OE;
  logic                         PROG_BUSY;
  logic                         PROG_UNLOCKED;
  logic [15:0]                  MEM_RD_DATA;
  wire logic                    line_out = SERIAL_OUT_OE ? SERIAL_OUT : 1'hz;
  logic [15:0]                  exp_word;
  logic                         exp_unlk = 1'h0;
  logic                         filled = 1'h0;
  logic [31:0]                  rnd = 32'h42f52d80;
  int                           n_errors = 0;
  int                           comparisons = 0;
  // System clock.
  always #4 SYS_CLK = ~SYS_CLK;
  see_bulk_prog #(.ERASE_ALL_CYCLES(CYC), .WRITE_ALL_CYCLES(CYC)) u_see_bulk_prog (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .SCLK(SCLK), .CHIP_SELECT(CHIP_SELECT), .SERIAL_IN(SERIAL_IN),
    .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE), .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
    .PROGRAM_PERMIT(PROGRAM_PERMIT), .PROG_BUSY(PROG_BUSY), .PROG_UNLOCKED(PROG_UNLOCKED),
    .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_DATA(MEM_RD_DATA)
  );
  see_host_model u_see_host_model (.SCLK(SCLK), .CHIP_SELECT(CHIP_SELECT), .SERIAL_IN(SERIAL_IN));
  // Next value of the pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Moves to just after the next rising edge, where outputs are settled.
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reads every word through the observation port.
  task automatic check_mem();
    int a;
    for (a = 0; a < see_pkg::ARRAY_WORDS; a++) begin
      @(posedge SYS_CLK);
      MEM_RD_ADDR <= a[see_pkg::ARRAY_AW-1:0];
      repeat (3) tick();
      chk("array word", exp_word, MEM_RD_DATA);
    end
  endtask
  // Sends one opcode 00 command, predicts its effect and follows the status pin.
  task automatic op(input string nm, input logic [1:0] sub, input bit drop);
    logic [31:0] v;
    logic [15:0] d;
    int          ab;
    int          db;
    int          i;
    bit          go;
    rnd = lfsr(rnd);
    d = rnd[15:0];
    ab = WORD_WIDTH_SELECT ? 10 : 11;
    db = (sub == see_pkg::CMD_WRITE_ALL) ? (WORD_WIDTH_SELECT ? 16 : 8) : 0;
    v = ((32'h10 | 32'(sub)) << (ab - 2)) | (32'(rnd[31:16]) & ((32'h1 << (ab - 2)) - 32'h1));
    v = (v << db) | (32'(d) & ((32'h1 << db) - 32'h1));
    go = 1'h0;
    case (sub)
      see_pkg::CMD_UNLOCK: exp_unlk = 1'h1;
      see_pkg::CMD_LOCK: exp_unlk = 1'h0;
      default: go = exp_unlk && PROGRAM_PERMIT;
    endcase
    if (go) exp_word = (db == 0) ? 16'hffff : ((db == 8) ? {d[7:0], d[7:0]} : d);
    filled = filled | go;
    u_see_host_model.frame(v, 3 + ab + db);
    if (go) begin
      for (i = 0; i < 40 && line_out !== 1'h0; i++) tick();
      chk("busy status", 16'h0, 16'(line_out));
      if (drop) begin
        u_see_host_model.deselect();
        repeat (8) tick();
        chk("released pin", {15'h0, 1'hz}, 16'(line_out));
        chk("busy after deselect", 16'h1, 16'(PROG_BUSY));
      end
      for (i = 0; i < CYC + 3000 && PROG_BUSY !== 1'h0; i++) tick();
      chk("busy cleared", 16'h0, 16'(PROG_BUSY));
      chk("cycle length", 16'h1, {15'h0, i + 60 >= CYC});
      repeat (3) tick();
      if (!drop) chk("ready status", 16'h1, 16'(line_out));
    end else begin
      repeat (40) tick();
      chk("idle pin", {15'h0, 1'hz}, 16'(line_out));
    end
    if (!drop) u_see_host_model.deselect();
    tick();
    chk("unlock latch", 16'(exp_unlk), 16'(PROG_UNLOCKED));
    if (filled) check_mem();
    $display("test %s done", nm);
  endtask
  // Reset, then the command sequence; reset is raised as an event so the link-side flops clear without a link clock.
  initial begin
    RESET <= 1'h1;
    repeat (20) @(posedge SYS_CLK);
    RESET <= 1'h0;
    repeat (3) tick();
    op("locked erase", see_pkg::CMD_ERASE_ALL, 1'h0);
    op("unlock", see_pkg::CMD_UNLOCK, 1'h0);
    op("erase with deselect", see_pkg::CMD_ERASE_ALL, 1'h1);
    op("write wide", see_pkg::CMD_WRITE_ALL, 1'h0);
    @(posedge SYS_CLK);
    WORD_WIDTH_SELECT <= 1'h0;
    tick();
    op("write narrow", see_pkg::CMD_WRITE_ALL, 1'h0);
    @(posedge SYS_CLK);
    PROGRAM_PERMIT <= 1'h0;
    repeat (8) tick();
    op("erase blocked", see_pkg::CMD_ERASE_ALL, 1'h0);
    @(posedge SYS_CLK);
    PROGRAM_PERMIT <= 1'h1;
    tick();
    op("lock", see_pkg::CMD_LOCK, 1'h0);
    op("write locked", see_pkg::CMD_WRITE_ALL, 1'h0);
    summarize();
  end
  // Cuts a hang short.
  initial begin
    #800000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
